//--- verilog/bmp_params.svh
// constants for the bubble page store: loop geometry, map layout, gate delays
// assumes includers use the bmp_ prefix and count delays in field cycles
`ifndef BMP_PARAMS_SVH
`define BMP_PARAMS_SVH

// ----------------------------------------------------------------------------
// loop geometry
// ----------------------------------------------------------------------------
`define BMP_LOOPS 32'h248          // 584 storage loops in total
`define BMP_USER_LOOPS 32'h200     // 512 user loops
`define BMP_ECC_LOOPS 32'hc        // 12 error-correction loops
`define BMP_SPARE_LOOPS 32'h3c     // 60 spare loops
`define BMP_LOOP_BITS 32'h800      // 2,048 positions per loop
`define BMP_POS_W 32'hb            // width of a loop position
`define BMP_DEAD_LOOP 32'h124      // loop 292 has no connection
`define BMP_POS_ONE 11'h001

// ----------------------------------------------------------------------------
// gate delays in field cycles
// ----------------------------------------------------------------------------
`define BMP_GS_FIRST 32'h255       // generate first bit to swap, 597
`define BMP_GS_LAST 32'he          // generate last bit to swap, 14
`define BMP_RD_FIRST 32'h5b        // replicate to first detect, 91
`define BMP_RD_LAST 32'h2a2        // replicate to last detect, 674
`define BMP_MRD 32'h61             // map replicate to detect, 97
`define BMP_GT1 32'h260            // generate to map loop 1 transfer, 608
`define BMP_GT2 32'h25d            // generate to map loop 2 transfer, 605
`define BMP_SWAP_TO_REP 11'h402    // swap gate leads replicate gate by 1026

// ----------------------------------------------------------------------------
// map loop layout
// ----------------------------------------------------------------------------
`define BMP_MAP_INFO 32'h400       // 1024 information bits
`define BMP_SYNC_ZEROS 32'h40      // 64 leading zeros
`define BMP_SYNC_BITS 32'h42       // 66 sync bits
`define BMP_CHK_BITS 32'hc         // 12 check bits
`define BMP_LID_BITS 32'h2
`define BMP_USER_BITS 32'h168      // 360 user bits
`define BMP_LID_LOOP1 2'h1         // map held in first map loop
`define BMP_LID_LOOP2 2'h2         // map held in second map loop
`define BMP_USER_BREAK 32'h20      // a one forced every 32 user bits
`define BMP_CHK_POLY 12'h80f       // check polynomial, plain default
`define BMP_FIFO_DEPTH 32'h8

`endif

//--- verilog/bmp_pkg.sv
// types used by the bubble page store; its detector buffer uses none of them
// assumes bmp_params.svh is on the include path
`include "bmp_params.svh"

package bmp_pkg;
    // ------------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------------
    typedef logic [`BMP_POS_W-1:0] bmp_pos_t;
    typedef logic [`BMP_LOOPS-1:0] bmp_page_t;

    // replicate gate sequencing: a cut holds a copy for a transfer on the next field cycle only
    typedef enum logic {
        BMP_REP_IDLE = 1'b0,
        BMP_REP_CUT = 1'b1
    } bmp_rep_e;
endpackage

//--- verilog/bmp_fifo_if.sv
// carrier between the page store and its detector buffer
// assumes one clock domain; both sides sample on the same edge
`timescale 1ns/1ps

interface bmp_fifo_if #(
    parameter int WIDTH = 1
) ();
    logic wr_valid;
    logic wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [WIDTH-1:0] rd_data;

    modport fifo (
        input wr_valid, wr_data, rd_ready,
        output wr_ready, rd_valid, rd_data
    );
    modport user (
        output wr_valid, wr_data, rd_ready,
        input wr_ready, rd_valid, rd_data
    );
endinterface

//--- verilog/bmp_fifo.sv
// small synchronous fifo with valid and ready on both sides
// assumes a synchronous active high reset and a clock enable that freezes it
`timescale 1ns/1ps
`include "bmp_params.svh"

module bmp_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = `BMP_FIFO_DEPTH
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    bmp_fifo_if.fifo q
);
    // ------------------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------------------
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic push;
    logic pop;

    // full and empty come straight from the count, so they never lie
    assign q.wr_ready = (count_r != FULL);
    assign q.rd_valid = (count_r != '0);
    assign q.rd_data = mem_r[rd_ptr_r];
    assign push = clk_en_in & q.wr_valid & q.wr_ready;
    assign pop = clk_en_in & q.rd_valid & q.rd_ready;

    // data words, no reset needed since empty masks them
    always_ff @(posedge core_clk_in) begin
        if (push) begin
            mem_r[wr_ptr_r] <= q.wr_data;
        end
    end

    // pointers wrap by compare so any depth works
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
            end
        end
    end

    // occupancy
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            count_r <= '0;
        end else if (push && !pop) begin
            count_r <= count_r + 1'b1;
        end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
        end
    end
endmodule

//--- verilog/bmp_page_store.sv
// page store of a one-megabit bubble chip: loops, tracks, gates, map loops
// assumes one field cycle per accepted step and gate pulses sampled on it
`timescale 1ns/1ps
`include "bmp_params.svh"

module bmp_page_store #(
    parameter int FIFO_DEPTH = `BMP_FIFO_DEPTH,
    parameter bit MAP_LOOP_SEL = 1'b0,
    parameter logic [`BMP_LOOPS-1:0] MAP_USABLE = {{59{1'b0}}, {525{1'b1}}},
    parameter logic [`BMP_USER_BITS-1:0] MAP_USER = '0,
    parameter logic [11:0] MAP_CHK_POLY = `BMP_CHK_POLY
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic field_step_in,
    output logic field_ready_out,
    input wire logic gen_pulse_in,
    input wire logic swap_pulse_in,
    input wire logic rep_cut_in,
    input wire logic rep_xfer_in,
    input wire logic map_rep_in,
    input wire logic map_xfer_in,
    output logic [`BMP_POS_W-1:0] gate_pos_out,
    output logic det_valid_out,
    output logic det_bit_out,
    input wire logic det_ready_in
);
    // ------------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------------
    localparam int LOOPS = `BMP_LOOPS;
    localparam int NPOS = `BMP_LOOP_BITS;
    localparam int IN_LEN = `BMP_GT1;
    localparam int OUT_LEN = `BMP_RD_LAST;

    // position arithmetic modulo the loop length
    function automatic bmp_pkg::bmp_pos_t pos_add(input bmp_pkg::bmp_pos_t a,
                                                  input bmp_pkg::bmp_pos_t b);
        pos_add = bmp_pkg::bmp_pos_t'(a + b);
    endfunction

    // factory image of one map loop; information on even positions only
    function automatic logic [NPOS-1:0] map_image(input logic [1:0] lid);
        logic [`BMP_MAP_INFO-1:0] info;
        logic [11:0] chk;
        logic [NPOS-1:0] img;
        logic bit_v;
        int k;
        info = '0;
        chk = '0;
        img = '0;
        info[`BMP_SYNC_ZEROS] = 1'b1;
        for (k = 0; k < `BMP_LOOPS; k++) begin
            bit_v = MAP_USABLE[k] & (k != `BMP_DEAD_LOOP);
            info[`BMP_SYNC_BITS + k] = bit_v;
            chk = {chk[10:0], 1'b0} ^ ((chk[11] ^ bit_v) ? MAP_CHK_POLY : 12'h000);
        end
        for (k = 0; k < `BMP_CHK_BITS; k++) begin
            info[`BMP_SYNC_BITS + `BMP_LOOPS + k] = chk[11 - k];
        end
        info[`BMP_SYNC_BITS + `BMP_LOOPS + `BMP_CHK_BITS] = lid[1];
        info[`BMP_SYNC_BITS + `BMP_LOOPS + `BMP_CHK_BITS + 1] = lid[0];
        for (k = 0; k < `BMP_USER_BITS; k++) begin
            // a forced one every 32 bits breaks any 64-zero run
            info[`BMP_MAP_INFO - `BMP_USER_BITS + k] =
                MAP_USER[k] | ((k % `BMP_USER_BREAK) == (`BMP_USER_BREAK - 1));
        end
        for (k = 0; k < `BMP_MAP_INFO; k++) begin
            img[2 * k] = info[k];
        end
        map_image = img;
    endfunction

    // only the loop chosen at test carries the map
    localparam logic [NPOS-1:0] MAP1_IMG =
        MAP_LOOP_SEL ? '0 : map_image(`BMP_LID_LOOP1);
    localparam logic [NPOS-1:0] MAP2_IMG =
        MAP_LOOP_SEL ? map_image(`BMP_LID_LOOP2) : '0;
    localparam logic [IN_LEN-1:0] SWAP_MASK =
        {{(IN_LEN - `BMP_GS_FIRST){1'b0}}, {LOOPS{1'b1}}, {(`BMP_GS_LAST - 1){1'b0}}};
    localparam logic [IN_LEN-1:0] MAP_MASK =
        {1'b1, {(IN_LEN - `BMP_GT2 - 1){1'b0}}, 1'b1, {(`BMP_GT2 - 1){1'b0}}};

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    bmp_pkg::bmp_page_t mem_r [NPOS];
    bmp_pkg::bmp_page_t held_r;
    bmp_pkg::bmp_page_t swap_word;
    bmp_pkg::bmp_page_t rep_word;
    bmp_pkg::bmp_pos_t rot_r;
    bmp_pkg::bmp_pos_t swap_pos;
    bmp_pkg::bmp_rep_e rep_r;
    logic [NPOS-1:0] map1_r;
    logic [NPOS-1:0] map2_r;
    logic [IN_LEN-1:0] in_r;
    logic [IN_LEN-1:0] in_nxt;
    logic [IN_LEN-1:0] in_clr;
    logic [OUT_LEN-1:0] out_r;
    logic [OUT_LEN-1:0] out_nxt;
    logic step;
    logic load_data;
    logic map_bit;

    bmp_fifo_if #(.WIDTH(1)) det_q ();

    // ------------------------------------------------------------------------
    // field stepping and detector buffer
    // ------------------------------------------------------------------------
    // a full buffer holds the field back rather than lose detected bits
    assign step = clk_en_in & field_step_in & det_q.wr_ready;
    assign field_ready_out = det_q.wr_ready;
    assign det_q.wr_valid = step;
    assign det_q.wr_data = out_r[0];
    assign det_q.rd_ready = det_ready_in;
    assign det_valid_out = det_q.rd_valid;
    assign det_bit_out = det_q.rd_data;
    assign gate_pos_out = rot_r;

    bmp_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_det_fifo (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .q(det_q)
    );

    // rotation: position under the replicate gate, one per field cycle
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            rot_r <= '0;
        end else if (step) begin
            rot_r <= pos_add(rot_r, `BMP_POS_ONE);
        end
    end

    // swap gates sit upstream so a swapped page reaches replicate later
    assign swap_pos = pos_add(rot_r, `BMP_SWAP_TO_REP);

    // ------------------------------------------------------------------------
    // input track and swap
    // ------------------------------------------------------------------------
    // bit for loop i has travelled 597-i positions when the swap lands
    for (genvar i = 0; i < LOOPS; i++) begin : g_swap
        if (i == `BMP_DEAD_LOOP) begin : g_dead
            assign swap_word[i] = 1'b0;
        end else begin : g_live
            assign swap_word[i] = in_r[`BMP_GS_FIRST - 1 - i];
        end
    end

    // swapped and transferred bubbles leave the track
    always_comb begin
        in_clr = '0;
        if (swap_pulse_in) begin
            in_clr = in_clr | SWAP_MASK;
        end
        if (map_xfer_in) begin
            in_clr = in_clr | MAP_MASK;
        end
        in_nxt = {in_r[IN_LEN-2:0] & ~in_clr[IN_LEN-2:0], gen_pulse_in};
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            in_r <= '0;
        end else if (step) begin
            in_r <= in_nxt;
        end
    end

    // storage loops; old page is simply dropped beyond the active area
    always_ff @(posedge core_clk_in) begin
        if (step && swap_pulse_in) begin
            mem_r[swap_pos] <= swap_word;
        end
    end

    // ------------------------------------------------------------------------
    // replicate gate
    // ------------------------------------------------------------------------
    // the unconnected loop never yields a bubble
    assign rep_word = mem_r[rot_r] & ~(bmp_pkg::bmp_page_t'(1) << `BMP_DEAD_LOOP);

    // cut copies the page, transfer on the very next cycle launches it
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            rep_r <= bmp_pkg::BMP_REP_IDLE;
            held_r <= '0;
        end else if (step) begin
            unique case (rep_r)
                bmp_pkg::BMP_REP_IDLE: begin
                    if (rep_cut_in) begin
                        rep_r <= bmp_pkg::BMP_REP_CUT;
                        held_r <= rep_word;
                    end
                end
                bmp_pkg::BMP_REP_CUT: begin
                    // a late transfer finds the copy collapsed
                    rep_r <= rep_cut_in ? bmp_pkg::BMP_REP_CUT : bmp_pkg::BMP_REP_IDLE;
                    if (rep_cut_in) begin
                        held_r <= rep_word;
                    end
                end
            endcase
        end
    end

    assign load_data = (rep_r == bmp_pkg::BMP_REP_CUT) & rep_xfer_in;

    // ------------------------------------------------------------------------
    // map loops
    // ------------------------------------------------------------------------
    // both outputs merge; only the loop chosen by MAP_LOOP_SEL starts with data, a transfer writes both
    assign map_bit = map1_r[rot_r] | map2_r[rot_r];

    // transfer-in takes the bubble lined up at each loop's own tap
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            map1_r <= MAP1_IMG;
            map2_r <= MAP2_IMG;
        end else if (step && map_xfer_in) begin
            map1_r[rot_r] <= map1_r[rot_r] | in_r[`BMP_GT1 - 1];
            map2_r[rot_r] <= map2_r[rot_r] | in_r[`BMP_GT2 - 1];
        end
    end

    // ------------------------------------------------------------------------
    // output track and detector
    // ------------------------------------------------------------------------
    // replicated bits join the track without disturbing bits already on it
    always_comb begin
        out_nxt = {1'b0, out_r[OUT_LEN-1:1]};
        if (load_data) begin
            out_nxt = out_nxt | {held_r, {(`BMP_RD_FIRST - 1){1'b0}}};
        end
        if (map_rep_in) begin
            out_nxt[`BMP_MRD - 1] = out_nxt[`BMP_MRD - 1] | map_bit;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            out_r <= '0;
        end else if (step) begin
            out_r <= out_nxt;
        end
    end
endmodule

//--- tb/bmp_page_store_sva.sv
// pin-level assertions for the bubble page store
// assumes one clock and a synchronous reset; bound to every page store
`timescale 1ns/1ps

module bmp_page_store_sva #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic field_step_in,
    input wire logic field_ready_out,
    input wire logic gen_pulse_in,
    input wire logic swap_pulse_in,
    input wire logic rep_cut_in,
    input wire logic rep_xfer_in,
    input wire logic map_rep_in,
    input wire logic map_xfer_in,
    input wire logic [10:0] gate_pos_out,
    input wire logic det_valid_out,
    input wire logic det_bit_out,
    input wire logic det_ready_in
);
    // ------------------------------------------------------------------------
    // buffer occupancy, counted apart from the design so its flags are judged
    // ------------------------------------------------------------------------
    logic step;
    logic pop;
    logic [4:0] fill_r;
    assign step = clk_en_in & field_step_in & field_ready_out;
    assign pop = clk_en_in & det_valid_out & det_ready_in;
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            fill_r <= 5'h00;
        end else begin
            fill_r <= fill_r + 5'(step) - 5'(pop);
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    reset_state_a: assert property ($fell(sys_rst_in) |->
        gate_pos_out == 11'h000 && !det_valid_out && field_ready_out)
        else $error("state after reset wrong");
    pos_step_a: assert property (step |=> gate_pos_out == $past(gate_pos_out) + 11'h001)
        else $error("gate position did not advance");
    pos_hold_a: assert property (!step |=> $stable(gate_pos_out))
        else $error("gate position moved without a step");
    step_push_a: assert property (step |=> det_valid_out)
        else $error("step left detector empty");
    ready_level_a: assert property (field_ready_out == (fill_r != 5'(FIFO_DEPTH)))
        else $error("ready flag disagrees with fill");
    valid_level_a: assert property (det_valid_out == (fill_r != 5'h00))
        else $error("valid flag disagrees with fill");
    head_stand_a: assert property (det_valid_out && !pop |=>
        det_valid_out && $stable(det_bit_out))
        else $error("detector head changed unpopped");
    freeze_hold_a: assert property (!clk_en_in |=>
        $stable(det_valid_out) && $stable(field_ready_out) && $stable(gate_pos_out))
        else $error("state moved with clock enable low");
    cover property (step && map_rep_in);
    cover property (step && rep_cut_in ##1 step && rep_xfer_in);
    cover property (step && swap_pulse_in && !gen_pulse_in);
    cover property (field_step_in && !field_ready_out);
endmodule

bind bmp_page_store bmp_page_store_sva #(.FIFO_DEPTH(FIFO_DEPTH)) i_bmp_page_store_sva (
    .core_clk_in, .sys_rst_in, .clk_en_in, .field_step_in, .field_ready_out,
    .gen_pulse_in, .swap_pulse_in, .rep_cut_in, .rep_xfer_in, .map_rep_in,
    .map_xfer_in, .gate_pos_out, .det_valid_out, .det_bit_out, .det_ready_in
);

//--- tb/bmp_ctrl_model.sv
// controller side of the detector output: drains bits and keeps them in order
// assumes the bench sequences field steps and gate pulses itself
`timescale 1ns/1ps

module bmp_ctrl_model (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic stall_in,
    input wire logic slow_in,
    input wire logic det_valid_in,
    input wire logic det_bit_in,
    output logic det_ready_out
);
    logic got[$];
    initial det_ready_out = 1'b0;
    // drain pace: prompt, every other cycle, or stalled to back the buffer up
    always @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            det_ready_out <= 1'b0;
        end else begin
            det_ready_out <= stall_in ? 1'b0 : (slow_in ? ~det_ready_out : 1'b1);
        end
    end
    // keep every bit, odd map positions too; the reader drops them later
    always @(posedge core_clk_in) begin
        if (!sys_rst_in && clk_en_in && det_valid_in && det_ready_out) begin
            got.push_back(det_bit_in);
        end
    end
endmodule

//--- tb/bmp_page_store_tb.sv
// bench for the bubble page store: map read, page write and read, map write,
// buffer full; assumes steps are counted from reset, one detected bit each
`timescale 1ns/1ps
`include "bmp_params.svh"

module bmp_page_store_tb;
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic clk_en_in = 1'b1;
    logic field_step_in = 1'b0;
    logic gen_pulse_in = 1'b0;
    logic swap_pulse_in = 1'b0;
    logic rep_cut_in = 1'b0;
    logic rep_xfer_in = 1'b0;
    logic map_rep_in = 1'b0;
    logic map_xfer_in = 1'b0;
    logic drain_stall = 1'b0;
    logic drain_slow = 1'b0;
    logic field_ready_out;
    logic [10:0] gate_pos_out;
    logic [10:0] gate_seen;
    logic det_valid_out;
    logic det_bit_out;
    logic det_ready_in;
    logic [583:0] usable;
    logic info [1024];
    int miscompares = 0;
    int comparisons = 0;
    int steps = 0;

    always #2.5 core_clk_in = ~core_clk_in;

    bmp_page_store i_bmp_page_store (
        .core_clk_in, .sys_rst_in, .clk_en_in, .field_step_in, .field_ready_out,
        .gen_pulse_in, .swap_pulse_in, .rep_cut_in, .rep_xfer_in, .map_rep_in,
        .map_xfer_in, .gate_pos_out, .det_valid_out, .det_bit_out, .det_ready_in
    );
    bmp_ctrl_model i_bmp_ctrl_model (
        .core_clk_in, .sys_rst_in, .clk_en_in, .stall_in(drain_stall),
        .slow_in(drain_slow), .det_valid_in(det_valid_out), .det_bit_in(det_bit_out),
        .det_ready_out(det_ready_in)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // one field cycle; g is gen, swap, cut, xfer, map rep, map xfer; waits out a full buffer
    task automatic step(input logic [5:0] g);
        int n;
        n = 0;
        field_step_in <= 1'b1;
        {gen_pulse_in, swap_pulse_in, rep_cut_in, rep_xfer_in, map_rep_in, map_xfer_in} <= g;
        // ready only moves on a rising edge, so the falling edge shows what the next edge takes
        @(negedge core_clk_in);
        while (field_ready_out !== 1'b1) begin
            n++;
            if (n > 64) begin
                miscompares++;
                conclude();
            end
            @(negedge core_clk_in);
        end
        gate_seen = gate_pos_out;
        @(posedge core_clk_in);
        steps++;
    endtask
    // stop stepping until every pushed bit has reached the controller
    task automatic flush();
        int n;
        n = 0;
        field_step_in <= 1'b0;
        do begin
            @(posedge core_clk_in);
            n++;
            if (n > 200) begin
                miscompares++;
                conclude();
            end
        end while (i_bmp_ctrl_model.got.size() < steps);
    endtask
    function automatic logic seen_bit(input int k);
        return i_bmp_ctrl_model.got[k];
    endfunction

    task automatic t_reset();
        check("gate position", 32'(gate_pos_out), 32'h0);
        check("detector valid", 32'(det_valid_out), 32'h0);
        check("field ready", 32'(field_ready_out), 32'h1);
    endtask
    task automatic t_map_read();
        logic [11:0] chk;
        logic [31:0] ones;
        int run;
        int worst;
        usable = {{59{1'b0}}, {525{1'b1}}};
        usable[292] = 1'b0;
        chk = 12'h000;
        ones = 32'h0;
        run = 0;
        worst = 0;
        for (int k = 0; k < 66; k++) info[k] = (k == 64);
        for (int i = 0; i < 584; i++) begin
            info[66 + i] = usable[i];
            chk = {chk[10:0], 1'b0} ^ ((chk[11] ^ usable[i]) ? `BMP_CHK_POLY : 12'h000);
        end
        for (int j = 0; j < 12; j++) info[650 + j] = chk[11 - j];
        info[662] = 1'b0;
        info[663] = 1'b1;
        for (int j = 0; j < 360; j++) info[664 + j] = (j % 32 == 31);
        drain_slow <= 1'b1;
        // alternate-cycle pass on even positions, then repeated one cycle later
        for (int c = 0; c < 4096; c++) step({4'h0, (c % 2) == (c / 2048), 1'b0});
        repeat (100) step(6'h00);
        flush();
        for (int c = 0; c < 4096; c++) begin
            if ((c % 2) == (c / 2048)) begin
                check("map bit", 32'(seen_bit(c + `BMP_MRD)),
                    32'((c % 2 == 0) && info[(c % 2048) / 2]));
            end
        end
        for (int i = 0; i < 584; i++) ones = ones + 32'(seen_bit(2 * (66 + i) + 97));
        check("usable loops", ones, 32'd524);
        check("dead loop", 32'(seen_bit(2 * 358 + 97)), 32'h0);
        check("loop id", 32'({seen_bit(1421), seen_bit(1423)}), 32'(`BMP_LID_LOOP1));
        for (int j = 0; j < 360; j++) begin
            run = (seen_bit(2 * (664 + j) + 97) === 1'b1) ? 0 : run + 1;
            worst = (run > worst) ? run : worst;
        end
        check("user zero run short", 32'(worst < 64), 32'h1);
    endtask
    task automatic t_page();
        logic [583:0] pat;
        logic [10:0] home;
        int c;
        for (int i = 0; i < 584; i++) pat[i] = (i[0] ^ i[3]) & usable[i];
        drain_slow <= 1'b0;
        // 584 bits, 13 blanks after the block, swap 597 after the first bit
        for (int i = 0; i < 598; i++) begin
            if (i == 597) home = 11'(steps) + `BMP_SWAP_TO_REP;
            step({(i < 584) && pat[i], i == 597, 4'h0});
        end
        while (11'(steps) != home) step(6'h00);
        c = steps;
        step(6'h08);
        check("gate at cut", 32'(gate_seen), 32'(home));
        step(6'h04);
        repeat (690) step(6'h00);
        flush();
        check("before page", 32'(seen_bit(c + `BMP_RD_FIRST)), 32'h0);
        for (int i = 0; i < 584; i++) begin
            check("page bit", 32'(seen_bit(c + 1 + `BMP_RD_FIRST + i)),
                32'(pat[i]));
        end
    endtask
    task automatic t_map_write();
        int d;
        int c;
        logic [10:0] spot;
        for (int n = 0; n < 2; n++) begin
            d = n ? `BMP_GT2 : `BMP_GT1;
            // land on an odd position, empty in the factory image
            while ((steps + d) % 2 == 0) step(6'h00);
            step(6'h20);
            repeat (d - 1) step(6'h00);
            spot = 11'(steps);
            step(6'h01);
            while (11'(steps) != spot) step(6'h00);
            c = steps;
            step(6'h02);
            repeat (100) step(6'h00);
            flush();
            check("map write", 32'(seen_bit(c + `BMP_MRD)), 32'h1);
        end
    endtask
    task automatic t_fifo();
        logic [10:0] held;
        drain_stall <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        repeat (`BMP_FIFO_DEPTH) step(6'h00);
        @(negedge core_clk_in);
        check("ready when full", 32'(field_ready_out), 32'h0);
        held = gate_pos_out;
        repeat (3) @(posedge core_clk_in);
        check("refused step", 32'(gate_pos_out), 32'(held));
        clk_en_in <= 1'b0;
        drain_stall <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        check("frozen valid", 32'(det_valid_out), 32'h1);
        // a pop while frozen would have freed a slot and raised ready
        check("frozen ready", 32'(field_ready_out), 32'h0);
        clk_en_in <= 1'b1;
        flush();
        @(negedge core_clk_in);
        check("drained valid", 32'(det_valid_out), 32'h0);
        check("drained ready", 32'(field_ready_out), 32'h1);
    endtask

    initial begin
        repeat (4) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge core_clk_in);
        t_reset();
        t_map_read();
        t_page();
        t_map_write();
        t_fifo();
        conclude();
    end
endmodule
